//--- verilog/bcrf_top.v
// Backup clock control and reset cause registers with APB slave
`timescale 1ns/1ps
`default_nettype none
`include "bcrf_map.vh"

// Three-stage input synchroniser; output follows once stages two and three
// agree, so a single metastable sample never reaches the logic.
module bcrf_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output reg  [WIDTH-1:0] q
);
  reg [WIDTH-1:0] s1_r;
  reg [WIDTH-1:0] s2_r;
  reg [WIDTH-1:0] s3_r;
  integer i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= {WIDTH{1'b0}};
      s2_r <= {WIDTH{1'b0}};
      s3_r <= {WIDTH{1'b0}};
      q    <= {WIDTH{1'b0}};
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (s2_r[i] == s3_r[i]) begin
          q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule

module bcrf_top (
  input  wire                   ref_clk,
  input  wire                   arst_n,
  input  wire                   bkp_por_n,
  input  wire                   sys_rst_n,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`BCRF_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  input  wire [3:0]             pstrb,
  output wire                   pready,
  output reg  [31:0]            prdata,
  output reg                    pslverr,
  input  wire                   backup_write_enable,
  input  wire                   slow_crystal_ready,
  input  wire                   internal_slow_osc_ready,
  input  wire                   slow_crystal_clock,
  input  wire                   internal_slow_clock,
  input  wire                   fast_crystal_clock,
  input  wire                   lowpower_reset_event,
  input  wire                   window_watchdog_reset_event,
  input  wire                   free_watchdog_reset_event,
  input  wire                   software_reset_event,
  input  wire                   pin_reset_event,
  output reg                    slow_crystal_enable,
  output reg                    slow_crystal_bypass,
  output reg                    internal_slow_osc_enable,
  output reg  [1:0]             rtc_source_select,
  output reg                    rtc_clock_gate,
  output reg                    rtc_clock,
  output reg                    backup_domain_reset
);

  // Release of the power reset and the backup-domain reset
  reg        prst1_r;
  reg        prst_n_r;
  reg        brst1_r;
  reg        brst_n_r;

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prst1_r  <= 1'b0;
      prst_n_r <= 1'b0;
    end else begin
      prst1_r  <= 1'b1;
      prst_n_r <= prst1_r;
    end
  end

  always @(posedge ref_clk or negedge bkp_por_n) begin
    if (!bkp_por_n) begin
      brst1_r  <= 1'b0;
      brst_n_r <= 1'b0;
    end else begin
      brst1_r  <= 1'b1;
      brst_n_r <= brst1_r;
    end
  end

  // Pins from other domains
  wire [`BCRF_NSYNC-1:0] async_in;
  wire [`BCRF_NSYNC-1:0] sync_q;

  assign async_in = {sys_rst_n,
                     pin_reset_event,
                     software_reset_event,
                     free_watchdog_reset_event,
                     window_watchdog_reset_event,
                     lowpower_reset_event,
                     fast_crystal_clock,
                     internal_slow_clock,
                     slow_crystal_clock,
                     internal_slow_osc_ready,
                     slow_crystal_ready};

  bcrf_sync #(
    .WIDTH (`BCRF_NSYNC)
  ) u_sync (
    .clk   (ref_clk),
    .rst_n (prst_n_r),
    .d     (async_in),
    .q     (sync_q)
  );

  wire       xtal_rdy_s;
  wire       irc_rdy_s;
  wire       xclk_s;
  wire       iclk_s;
  wire       hclk_s;
  wire [4:0] cause_s;
  wire       sys_rst_s_n;

  assign xtal_rdy_s  = sync_q[0];
  assign irc_rdy_s   = sync_q[1];
  assign xclk_s      = sync_q[2];
  assign iclk_s      = sync_q[3];
  assign hclk_s      = sync_q[4];
  assign cause_s     = sync_q[9:5];
  // Held high during the synchroniser reset, then low after its release until sync_q[10] rises
  assign sys_rst_s_n = sync_q[10] | ~prst_n_r;

  // APB decode
  wire        setup_ph;
  wire        wr_acc;
  wire        hit_bdc;
  wire        hit_rsc;
  wire [31:0] wmask;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign hit_bdc  = (paddr == `BCRF_OFF_BDC);
  assign hit_rsc  = (paddr == `BCRF_OFF_RSC);
  assign pready   = 1'b1;
  assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}},
                     {8{pstrb[1]}}, {8{pstrb[0]}}};

  wire wr_bdc;
  wire wr_rsc;
  wire bkp_wr;

  assign wr_bdc = wr_acc & hit_bdc;
  assign wr_rsc = wr_acc & hit_rsc;
  assign bkp_wr = wr_bdc & backup_write_enable;

  // Backup domain: software request and field reset
  reg  breq_r;
  wire bkp_clr;

  always @(posedge ref_clk or negedge brst_n_r) begin
    if (!brst_n_r) begin
      breq_r <= 1'b0;
    end else if (wr_bdc && wmask[`BCRF_BDC_BREQ_BIT]) begin
      breq_r <= pwdata[`BCRF_BDC_BREQ_BIT];
    end
  end

  // Request holds the fields in reset for as long as it stays set
  assign bkp_clr = breq_r;

  always @(posedge ref_clk or negedge brst_n_r) begin
    if (!brst_n_r) begin
      backup_domain_reset <= 1'b1;
    end else begin
      backup_domain_reset <= breq_r;
    end
  end

  // Backup fields, cleared only by the backup-domain reset
  always @(posedge ref_clk or negedge brst_n_r) begin
    if (!brst_n_r) begin
      slow_crystal_enable <= 1'b0;
      slow_crystal_bypass <= 1'b0;
      rtc_source_select   <= `BCRF_SRC_NONE;
      rtc_clock_gate      <= 1'b0;
    end else if (bkp_clr) begin
      slow_crystal_enable <= 1'b0;
      slow_crystal_bypass <= 1'b0;
      rtc_source_select   <= `BCRF_SRC_NONE;
      rtc_clock_gate      <= 1'b0;
    end else if (bkp_wr) begin
      if (wmask[`BCRF_BDC_XEN_BIT]) begin
        slow_crystal_enable <= pwdata[`BCRF_BDC_XEN_BIT];
      end
      if (wmask[`BCRF_BDC_XBPS_BIT]) begin
        slow_crystal_bypass <= pwdata[`BCRF_BDC_XBPS_BIT];
      end
      if (wmask[`BCRF_BDC_SRC_LO] &&
          rtc_source_select == `BCRF_SRC_NONE) begin
        rtc_source_select <=
          pwdata[`BCRF_BDC_SRC_HI:`BCRF_BDC_SRC_LO];
      end
      if (wmask[`BCRF_BDC_GATE_BIT]) begin
        rtc_clock_gate <= pwdata[`BCRF_BDC_GATE_BIT];
      end
    end
  end

  // Stability flags follow the enable so a stale ready never reads as 1
  reg xstb_r;
  reg istb_r;

  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      xstb_r <= 1'b0;
      istb_r <= 1'b0;
    end else begin
      xstb_r <= slow_crystal_enable & xtal_rdy_s;
      istb_r <= internal_slow_osc_enable & irc_rdy_s;
    end
  end

  // Reset cause flags, power reset only
  reg  [4:0] cause_d_r;
  wire [4:0] cause_rise;
  reg        clr_r;
  wire       clr_pulse;
  reg        lp_f_r;
  reg        wwd_f_r;
  reg        fwd_f_r;
  reg        sw_f_r;
  reg        por_f_r;
  reg        pin_f_r;

  assign cause_rise = cause_s & ~cause_d_r;
  assign clr_pulse  = wr_rsc & wmask[`BCRF_RSC_CLR_BIT] &
                      pwdata[`BCRF_RSC_CLR_BIT];

  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      cause_d_r <= 5'h00;
      lp_f_r    <= 1'b0;
      wwd_f_r   <= 1'b0;
      fwd_f_r   <= 1'b0;
      sw_f_r    <= 1'b0;
      por_f_r   <= 1'b1;
      pin_f_r   <= 1'b1;
    end else begin
      cause_d_r <= cause_s;
      // A cause arriving with the clear survives it
      lp_f_r  <= cause_rise[0] | (lp_f_r  & ~clr_pulse);
      wwd_f_r <= cause_rise[1] | (wwd_f_r & ~clr_pulse);
      fwd_f_r <= cause_rise[2] | (fwd_f_r & ~clr_pulse);
      sw_f_r  <= cause_rise[3] | (sw_f_r  & ~clr_pulse);
      por_f_r <= por_f_r & ~clr_pulse;
      pin_f_r <= cause_rise[4] | (pin_f_r & ~clr_pulse);
    end
  end

  // Clear bit and 40 kHz enable, system reset scope
  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      clr_r                    <= 1'b0;
      internal_slow_osc_enable <= 1'b0;
    end else if (!sys_rst_s_n) begin
      clr_r                    <= 1'b0;
      internal_slow_osc_enable <= 1'b0;
    end else if (wr_rsc) begin
      if (wmask[`BCRF_RSC_CLR_BIT]) begin
        clr_r <= pwdata[`BCRF_RSC_CLR_BIT];
      end
      if (wmask[`BCRF_RSC_IEN_BIT]) begin
        internal_slow_osc_enable <= pwdata[`BCRF_RSC_IEN_BIT];
      end
    end
  end

  // RTC clock path: edges of the sampled sources, divider for fast crystal
  reg  [`BCRF_HDIV_W-1:0] hdiv_r;
  reg                     hclk_d_r;
  reg                     hdiv_clk_r;
  reg                     rtc_sel_clk;

  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      hdiv_r     <= {`BCRF_HDIV_W{1'b0}};
      hclk_d_r   <= 1'b0;
      hdiv_clk_r <= 1'b0;
    end else begin
      hclk_d_r <= hclk_s;
      if (hclk_s && !hclk_d_r) begin
        // Toggle every 64 rising edges gives a period of 128
        if (hdiv_r == `BCRF_HDIV_HALF) begin
          hdiv_r     <= {`BCRF_HDIV_W{1'b0}};
          hdiv_clk_r <= ~hdiv_clk_r;
        end else begin
          hdiv_r <= hdiv_r + {{(`BCRF_HDIV_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  always @* begin
    case (rtc_source_select)
      `BCRF_SRC_XTAL: rtc_sel_clk = xclk_s;
      `BCRF_SRC_IRC:  rtc_sel_clk = iclk_s;
      `BCRF_SRC_HDIV: rtc_sel_clk = hdiv_clk_r;
      default:        rtc_sel_clk = 1'b0;
    endcase
  end

  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      rtc_clock <= 1'b0;
    end else begin
      rtc_clock <= rtc_sel_clk & rtc_clock_gate;
    end
  end

  // Read-back images; reserved positions show their reset value
  wire [31:0] bdc_img;
  wire [31:0] rsc_img;

  assign bdc_img = `BCRF_BDC_RESET |
                   ({31'h0, slow_crystal_enable} << `BCRF_BDC_XEN_BIT) |
                   ({31'h0, xstb_r} << `BCRF_BDC_XSTB_BIT) |
                   ({31'h0, slow_crystal_bypass} << `BCRF_BDC_XBPS_BIT) |
                   ({30'h0, rtc_source_select} << `BCRF_BDC_SRC_LO) |
                   ({31'h0, rtc_clock_gate} << `BCRF_BDC_GATE_BIT) |
                   ({31'h0, breq_r} << `BCRF_BDC_BREQ_BIT);

  assign rsc_img = ({31'h0, internal_slow_osc_enable} << `BCRF_RSC_IEN_BIT) |
                   ({31'h0, istb_r} << `BCRF_RSC_ISTB_BIT) |
                   ({31'h0, clr_r} << `BCRF_RSC_CLR_BIT) |
                   ({31'h0, pin_f_r} << `BCRF_RSC_PIN_BIT) |
                   ({31'h0, por_f_r} << `BCRF_RSC_POR_BIT) |
                   ({31'h0, sw_f_r} << `BCRF_RSC_SW_BIT) |
                   ({31'h0, fwd_f_r} << `BCRF_RSC_FWD_BIT) |
                   ({31'h0, wwd_f_r} << `BCRF_RSC_WWD_BIT) |
                   ({31'h0, lp_f_r} << `BCRF_RSC_LP_BIT);

  // Read data captured in setup so it stands through the access cycle
  always @(posedge ref_clk or negedge prst_n_r) begin
    if (!prst_n_r) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      pslverr <= ~(hit_bdc | hit_rsc);
      if (hit_bdc) begin
        prdata <= bdc_img;
      end else if (hit_rsc) begin
        prdata <= rsc_img;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

//--- verilog/bcrf_map.vh
// Register offsets, field positions and reset values for the block
`ifndef BCRF_MAP_VH
`define BCRF_MAP_VH

`define BCRF_ADDR_W          8
`define BCRF_OFF_BDC         8'h20
`define BCRF_OFF_RSC         8'h24

`define BCRF_BDC_RESET       32'h00000018
`define BCRF_RSC_RESET       32'h0C000000

`define BCRF_BDC_XEN_BIT     0
`define BCRF_BDC_XSTB_BIT    1
`define BCRF_BDC_XBPS_BIT    2
`define BCRF_BDC_SRC_LO      8
`define BCRF_BDC_SRC_HI      9
`define BCRF_BDC_GATE_BIT    15
`define BCRF_BDC_BREQ_BIT    16

`define BCRF_RSC_IEN_BIT     0
`define BCRF_RSC_ISTB_BIT    1
`define BCRF_RSC_CLR_BIT     24
`define BCRF_RSC_PIN_BIT     26
`define BCRF_RSC_POR_BIT     27
`define BCRF_RSC_SW_BIT      28
`define BCRF_RSC_FWD_BIT     29
`define BCRF_RSC_WWD_BIT     30
`define BCRF_RSC_LP_BIT      31

`define BCRF_SRC_NONE        2'h0
`define BCRF_SRC_XTAL        2'h1
`define BCRF_SRC_IRC         2'h2
`define BCRF_SRC_HDIV        2'h3

`define BCRF_HDIV_W          7
`define BCRF_HDIV_HALF       7'h3F

`define BCRF_NSYNC           11

`endif

//--- tb/bcrf_props.sv
// Concurrent checks on the ports of the backup clock and reset block
`timescale 1ns/1ps
`default_nettype none
module bcrf_props (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        bkp_por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        backup_write_enable,
  input wire logic        slow_crystal_enable,
  input wire logic        slow_crystal_bypass,
  input wire logic        internal_slow_osc_enable,
  input wire logic [1:0]  rtc_source_select,
  input wire logic        rtc_clock_gate,
  input wire logic        rtc_clock,
  input wire logic        backup_domain_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n || !bkp_por_n);
  wire       su = psel && !penable && !pwrite;
  wire       wa = psel && penable && pwrite;
  wire [2:0] bk = {slow_crystal_enable, slow_crystal_bypass, rtc_clock_gate};
  src_lock_a: assert property (rtc_source_select != 2'h0 |=>
    $stable(rtc_source_select) || backup_domain_reset)
    else $error("source select changed while locked");
  wen_a: assert property (!(wa && backup_write_enable) |=>
    $stable(bk) || backup_domain_reset)
    else $error("backup field changed without write enable");
  breq_a: assert property (wa && paddr == 8'h20 && pstrb[2] &&
    pwdata[16] |-> ##[1:2] backup_domain_reset)
    else $error("backup reset request not seen");
  // Two cycles of slack: the clear lands on the same edge that raises the reset flag
  rst_clr_a: assert property (backup_domain_reset [*2] |->
    bk == 3'h0 && rtc_source_select == 2'h0)
    else $error("backup fields not cleared under reset");
  gate_a: assert property (!rtc_clock_gate [*8] |-> !rtc_clock)
    else $error("rtc clock passes while gated");
  none_a: assert property ((rtc_source_select == 2'h0) [*8] |->
    !rtc_clock)
    else $error("rtc clock runs with no source");
  unmap_a: assert property (su && paddr != 8'h20 && paddr != 8'h24
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  bdc_rsv_a: assert property (su && paddr == 8'h20 |=>
    prdata[31:17] == 15'h0 && prdata[14:10] == 5'h0 && prdata[7:3] == 5'h03)
    else $error("reserved bits of backup control wrong");
  rsc_rsv_a: assert property (su && paddr == 8'h24 |=>
    !prdata[25] && prdata[23:2] == 22'h0)
    else $error("reserved bits of reset cause wrong");
  bdc_rd_a: assert property (su && paddr == 8'h20 |=>
    prdata[2] == $past(slow_crystal_bypass) &&
    prdata[0] == $past(slow_crystal_enable))
    else $error("backup control read does not match outputs");
  ien_a: assert property (su && paddr == 8'h24 |=>
    prdata[0] == $past(internal_slow_osc_enable))
    else $error("oscillator enable read does not match output");
  lock_c: cover property (rtc_source_select == 2'h3);
  breq_c: cover property ($rose(backup_domain_reset));
  err_c: cover property (pslverr);
endmodule
bind bcrf_top bcrf_props u_props (.*);
`default_nettype wire

//--- tb/bcrf_osc_model.sv
// Behavioural model of the slow oscillators and the fast crystal
`timescale 1ns/1ps
`default_nettype none
module bcrf_osc_model #(
  parameter int XDLY = 40,
  parameter int IDLY = 30
) (
  input  wire logic ref_clk,
  input  wire logic slow_crystal_enable,
  input  wire logic internal_slow_osc_enable,
  output logic      slow_crystal_ready,
  output logic      internal_slow_osc_ready,
  output logic      slow_crystal_clock,
  output logic      internal_slow_clock,
  output logic      fast_crystal_clock
);
  int         xc = 0;
  int         ic = 0;
  logic [3:0] ph = 4'h0;
  initial {slow_crystal_ready, internal_slow_osc_ready} = 2'h0;
  initial {slow_crystal_clock, internal_slow_clock} = 2'h0;
  initial fast_crystal_clock = 1'b0;
  // Startup time: ready only after a settling count, dropped when off
  always @(posedge ref_clk) begin
    xc <= !slow_crystal_enable ? 0 : (xc < XDLY ? xc + 1 : xc);
    ic <= !internal_slow_osc_enable ? 0 : (ic < IDLY ? ic + 1 : ic);
    slow_crystal_ready <= slow_crystal_enable && xc == XDLY;
    internal_slow_osc_ready <= internal_slow_osc_enable && ic == IDLY;
    ph <= ph + 4'h1;
    fast_crystal_clock <= ph[1];
    // A stopped oscillator holds its level rather than running free
    if (slow_crystal_enable && ph[2:0] == 3'h7)
      slow_crystal_clock <= ~slow_crystal_clock;
    if (internal_slow_osc_enable && ph == 4'hF)
      internal_slow_clock <= ~internal_slow_clock;
  end
endmodule
`default_nettype wire

//--- tb/bcrf_top_tb.sv
// Self-checking bench for the backup clock and reset cause registers
`timescale 1ns/1ps
`default_nettype none
module bcrf_top_tb;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        bkp_por_n = 1'b0;
  logic        sys_rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic        backup_write_enable = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [31:0] rd;
  logic        er;
  int          n_errors = 0;
  int          comparisons = 0;
  wire         lowpower_reset_event = ev[4];
  wire         window_watchdog_reset_event = ev[3];
  wire         free_watchdog_reset_event = ev[2];
  wire         software_reset_event = ev[1];
  wire         pin_reset_event = ev[0];
  wire [31:0]  prdata;
  wire [1:0]   rtc_source_select;
  wire         pready, pslverr, slow_crystal_ready, internal_slow_osc_ready;
  wire         slow_crystal_clock, internal_slow_clock, fast_crystal_clock;
  wire         slow_crystal_enable, slow_crystal_bypass, rtc_clock_gate;
  wire         internal_slow_osc_enable, rtc_clock, backup_domain_reset;
  bcrf_top dut (.*);
  bcrf_osc_model u_osc (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  task conclude;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input [31:0] s, input [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task apb(input [7:0] a, input w, input [31:0] d, input [3:0] s);
    int k;
    @(posedge ref_clk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'h2, w, a, d, s};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      k++;
      if (k > 20) begin
        n_errors++;
        conclude;
      end
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    apb(a, 1'b1, d, s);
  endtask
  task rc(input [7:0] a, input [31:0] e);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk("prdata", rd, e);
  endtask
  task tog(input int c, output int t);
    logic p;
    t = 0;
    p = rtc_clock;
    repeat (c) begin
      @(posedge ref_clk);
      if (rtc_clock !== p) t++;
      p = rtc_clock;
    end
  endtask
  task t_wen;
    wr(8'h20, 32'h8105, 4'hF);
    rc(8'h20, 32'h18);
    backup_write_enable <= 1'b1;
    wr(8'h20, 32'h8105, 4'h1);
    rc(8'h20, 32'h1D);
    wt(60);
    rc(8'h20, 32'h1F);
    #1 chk("bypass", slow_crystal_bypass, 1);
    wr(8'h20, 32'h0, 4'h1);
    wt(10);
    rc(8'h20, 32'h18);
  endtask
  task t_src;
    int t;
    logic [31:0] d;
    for (int s = 0; s < 4; s++) begin
      wr(8'h20, 32'h10000, 4'h4);
      wt(3);
      #1 chk("bkp reset", backup_domain_reset, 1);
      rc(8'h20, 32'h10018);
      wr(8'h20, 32'h0, 4'h4);
      d = 32'h8001 | (s << 8);
      wr(8'h20, d, 4'hF);
      wt(60);
      rc(8'h20, d | 32'h1A);
      if (s != 0) begin
        wr(8'h20, d ^ 32'h300, 4'h2);
        rc(8'h20, d | 32'h1A);
      end
      tog(1200, t);
      chk("rtc runs", t > 0, s != 0);
      wr(8'h20, d & 32'h301, 4'h2);
      wt(20);
      tog(100, t);
      chk("rtc gated", t, 0);
    end
  endtask
  task t_flags;
    logic [31:0] e;
    wr(8'h24, 32'h01000000, 4'h8);
    rc(8'h24, 32'h01000000);
    wr(8'h24, 32'h0, 4'h8);
    rc(8'h24, 32'h0);
    e = 32'h0;
    for (int i = 0; i < 5; i++) begin
      ev <= 5'h10 >> i;
      wt(8);
      ev <= 5'h00;
      wt(10);
      e = e | (32'h1 << (i == 4 ? 26 : 31 - i));
      rc(8'h24, e);
    end
    wr(8'h24, 32'h0, 4'h8);
    rc(8'h24, e);
    wr(8'h24, 32'h01000000, 4'h8);
    rc(8'h24, 32'h01000000);
    wr(8'h24, 32'h1, 4'h1);
    wt(40);
    rc(8'h24, 32'h01000003);
  endtask
  task t_scope;
    ev <= 5'h01;
    wt(8);
    ev <= 5'h00;
    wt(10);
    rc(8'h24, 32'h05000003);
    sys_rst_n <= 1'b0;
    wt(8);
    sys_rst_n <= 1'b1;
    wt(10);
    rc(8'h24, 32'h04000000);
    rc(8'h20, 32'h31B);
    arst_n <= 1'b0;
    wt(3);
    arst_n <= 1'b1;
    wt(10);
    rc(8'h24, 32'h0C000000);
    rc(8'h20, 32'h31B);
  endtask
  task t_unmap;
    apb(8'h28, 1'b0, 32'h0, 4'h0);
    chk("pslverr", er, 1);
    wr(8'h28, 32'hFFFFFFFF, 4'hF);
    wr(8'h20, 32'hFFFE7FF9, 4'hF);
    rc(8'h20, 32'h31B);
    wr(8'h24, 32'h02FFFFFC, 4'hF);
    rc(8'h24, 32'h0C000000);
  endtask
  initial begin
    wt(6);
    {arst_n, bkp_por_n, sys_rst_n} <= 3'h7;
    wt(4);
    rc(8'h20, 32'h18);
    rc(8'h24, 32'h0C000000);
    t_wen;
    // The 40 kHz source case needs that oscillator already running
    t_flags;
    t_src;
    t_scope;
    t_unmap;
    conclude;
  end
endmodule
`default_nettype wire
